// [rtl/decode_pkg.sv]
package decode_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OPC_PREFIX = 8'h11;
  localparam logic [7:0] OPC_MOV_ABS_IMM = 8'hCF;
  localparam logic [7:0] OPC_MOV_A_HL = 8'h8B;
  localparam logic [7:0] OPC_MOV_HLD_IMM = 8'hCA;
  localparam logic [7:0] OPC_MOV_SADDR_IMM = 8'hCD;
  localparam logic [7:0] OPC_MOV_SFR_IMM = 8'hCC;
  localparam logic [7:0] OPC_MOV_STATE_IMM = 8'hCE;
  localparam logic [7:0] OPC_MOVW_SADDRP = 8'hC9;
  localparam logic [7:0] OPC_MOVW_SFRP = 8'hCB;
  localparam logic [7:0] OPC_MOVW_AX_ABS = 8'hAF;
  localparam logic [7:0] OPC_SWAP_X = 8'h08;
  localparam logic [7:0] OPC_SWAP_R = 8'h61;
  localparam logic [7:0] OPC_UNITY_X = 8'hE0;
  localparam logic [7:0] OPC_UNITY_A = 8'hE1;
  localparam logic [7:0] OPC_BR_SHORT = 8'hEF;
  localparam logic [7:0] OPC_BR_LONG = 8'hEE;
  localparam logic [7:0] OPC_BR_ABS20 = 8'hEC;
  localparam logic [7:0] OPC_VECTOR_CALL = 8'h84;
  localparam logic [7:0] OPC_SET_BIT = 8'h71;

  // ==========================================================================
  // Register indices and address map
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [2:0] REG_L = 3'h6;
  localparam logic [2:0] REG_H = 3'h7;
  localparam logic [2:0] PAIR_AX = 3'h0;
  localparam logic [2:0] PAIR_HL = 3'h3;
  localparam logic [3:0] SEG_UPPER = 4'hF;
  localparam logic [7:0] SADDR_SPLIT = 8'h20;
  localparam logic [19:0] SADDR_BASE = 20'hFFE00;
  localparam logic [19:0] SFR_BASE = 20'hFFF00;
  localparam logic [19:0] VECTOR_BASE = 20'h00080;
  localparam logic [7:0] UNITY_VALUE = 8'h01;

  // ==========================================================================
  // Lengths (bytes without prefix) and cycle counts
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_3 = 2'h3;

  // ==========================================================================
  // Software register offsets
  localparam logic [3:0] OFS_GPR_LAST = 4'h7;
  localparam logic [3:0] OFS_SEG = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'h9;
  localparam logic [3:0] OFS_ADDR_LO = 4'hA;
  localparam logic [3:0] OFS_ADDR_HI = 4'hB;
  localparam logic [3:0] OFS_ADDR_SEG = 4'hC;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_PFX_BIT = 1;

  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    OP_NONE = 5'b00000, OP_MOV_ABS_IMM = 5'b00001, OP_MOV_A_HL = 5'b00010,
    OP_MOV_HLD_IMM = 5'b00011, OP_MOV_SADDR_IMM = 5'b00100, OP_MOV_SFR_IMM = 5'b00101,
    OP_MOV_STATE_IMM = 5'b00110, OP_MOVW_SADDRP = 5'b00111, OP_MOVW_SFRP = 5'b01000,
    OP_MOVW_AX_ABS = 5'b01001, OP_SWAP_X = 5'b01010, OP_SWAP_R = 5'b01011,
    OP_LOAD_UNITY = 5'b01100, OP_BR_SHORT = 5'b01101, OP_BR_LONG = 5'b01110,
    OP_BR_ABS20 = 5'b01111, OP_VECTOR_CALL = 5'b10000, OP_SET_BIT = 5'b10001,
    OP_ILLEGAL = 5'b10010
  } op_t;
  typedef enum logic [2:0] {
    FA_KEEP = 3'b000, FA_CLEAR = 3'b001, FA_SET = 3'b010, FA_RESULT = 3'b011, FA_RESTORE = 3'b100
  } flag_act_t;
  typedef struct packed {
    flag_act_t zero_flag;
    flag_act_t aux_half_carry_flag;
    flag_act_t carry_flag;
  } flag_ctl_t;
  typedef struct packed {
    logic [3:0] seg;
    logic [7:0] hi;
    logic [7:0] lo;
  } addr20_t;
  typedef struct packed {
    logic valid;
    logic [19:0] pc;
    logic [39:0] code;
  } dec_req_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic prefixed;
    logic [2:0] bytes;
    logic [1:0] cycles;
    addr20_t addr;
    logic word;
    flag_ctl_t flags;
    logic [15:0] imm16;
    logic [7:0] imm8;
    logic [2:0] imm_bit;
    logic [2:0] dst;
  } dec_out_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : decode_pkg

// [rtl/operand_decoder.sv]
// Notes on behaviour
// - Prefixed access forms a 20-bit address from segment register and 16-bit address.
// - Segment extension covers only the one instruction after the prefix.
// - No interrupt accepted between prefix and the instruction it modifies.
// - Byte 11H before a normal opcode is the prefix; opcodes keep their encodings.
// - Byte registers indexed 0..7 as X, A, C, B, E, D, L, H.
// - Register pairs indexed 0..3 as AX, BC, DE, HL.
// - Word accesses force address bit 0 to zero.
// - Short-direct byte field reaches FFE20H to FFF1FH.
// - Special-function operand reaches FFF00H to FFFFFH.
// - Vector table pointer selects even addresses 0080H to 00BFH only.
// - Each flag is kept, cleared, set, computed or restored.
// - Prefixed store immediate to HL plus byte: 4 bytes, 2 cycles.
// - Swap A with X is 1 byte, with other registers 2 bytes.
// - 20-bit values split into segment 19:16, high 15:8, low 7:0.
// - Immediate fields are 16, 8 or 3 bits wide.
// - Absolute 16 and 20, relative 8 and 16, indirect, segment forms.
// - Branch displacements are signed, 8 or 16 bits wide.
// - Byte accumulator A and word accumulator AX are implied operands.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
module operand_decoder
  import decode_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset
  input decode_pkg::dec_req_t dec_req, // Instruction to decode
  input wire logic irq_req, // Pending interrupt request
  input wire logic interrupt_accept_bit, // Interrupt enable state
  output logic irq_take, // Interrupt may be accepted now
  output decode_pkg::dec_out_t dec_out, // Decoded instruction
  output logic [7:0] acc_byte, // Accumulator A
  output logic [15:0] acc_word, // Accumulator pair AX
  input decode_pkg::reg_req_t reg_bus, // Register access request
  output logic [7:0] reg_rdata // Read data, one cycle after the strobe
);
  import decode_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0][7:0] gpr;
    logic [3:0] extension_segment_reg;
    logic pend;
    logic last_pfx;
    dec_out_t out;
    logic [7:0] rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  // ==========================================================================
  // Address helpers
  // Segment extension
  function automatic addr20_t ext_addr(input logic pfx, input logic [3:0] seg, input logic [15:0] a16);
    ext_addr = pfx ? {seg, a16} : {SEG_UPPER, a16};
  endfunction : ext_addr

  function automatic addr20_t saddr_map(input logic [7:0] ofs);
    if (ofs < SADDR_SPLIT)
    begin
      saddr_map = SFR_BASE | {12'h000, ofs};
    end
    else
    begin
      saddr_map = SADDR_BASE | {12'h000, ofs};
    end
  endfunction : saddr_map

  function automatic addr20_t word_even(input addr20_t a);
    word_even = a;
    word_even.lo[0] = 1'b0;
  endfunction : word_even

  // ==========================================================================
  // Decode and register access
  always_comb
  begin
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic pfx;
    logic uses_seg;
    logic [2:0] base_len;
    logic [1:0] base_cyc;
    logic [15:0] hl;
    dec_out_t o;
    b0 = dec_req.code[39:32];
    b1 = dec_req.code[31:24];
    b2 = dec_req.code[23:16];
    b3 = dec_req.code[15:8];
    pfx = state_ff.pend;
    uses_seg = 1'b0;
    base_len = LEN_1;
    base_cyc = CYC_1;
    hl = {state_ff.gpr[REG_H], state_ff.gpr[REG_L]};
    o = '0;
    nxt_state = state_ff;
    nxt_state.out.valid = 1'b0;
    nxt_state.rdata = 8'h00;

    if (reg_bus.rd)
    begin
      if (reg_bus.addr <= OFS_GPR_LAST)
      begin
        nxt_state.rdata = state_ff.gpr[reg_bus.addr[2:0]];
      end
      else
      begin
        unique case (reg_bus.addr)
          OFS_SEG: nxt_state.rdata = {4'h0, state_ff.extension_segment_reg};
          OFS_STAT: nxt_state.rdata = {6'h00, state_ff.last_pfx, state_ff.pend};
          OFS_ADDR_LO: nxt_state.rdata = state_ff.out.addr.lo;
          OFS_ADDR_HI: nxt_state.rdata = state_ff.out.addr.hi;
          OFS_ADDR_SEG: nxt_state.rdata = {4'h0, state_ff.out.addr.seg};
          default: nxt_state.rdata = 8'h00;
        endcase
      end
    end

    if (dec_req.valid)
    begin
      if (b0 == OPC_PREFIX)
      begin
        nxt_state.pend = 1'b1;
      end
      else
      begin
        nxt_state.pend = 1'b0;
        o.valid = 1'b1;
        o.prefixed = pfx;
        // Flags kept unless the op says otherwise
        o.flags = '{FA_KEEP, FA_KEEP, FA_KEEP};
        unique case (b0)
          OPC_MOV_ABS_IMM:
          begin
            o.op = OP_MOV_ABS_IMM;
            base_len = LEN_4;
            uses_seg = 1'b1;
            o.addr = ext_addr(pfx, state_ff.extension_segment_reg, {b2, b1});
            o.imm8 = b3;
          end
          OPC_MOV_A_HL:
          begin
            o.op = OP_MOV_A_HL;
            uses_seg = 1'b1;
            o.addr = ext_addr(pfx, state_ff.extension_segment_reg, hl);
            o.dst = REG_A;
          end
          OPC_MOV_HLD_IMM:
          begin
            o.op = OP_MOV_HLD_IMM;
            // Three bytes plus prefix, one cycle plus one
            base_len = LEN_3;
            uses_seg = 1'b1;
            o.imm8 = b2;
            if (pfx)
            begin
              o.addr = {state_ff.extension_segment_reg, hl} + {12'h000, b1};
            end
            else
            begin
              o.addr = {SEG_UPPER, hl + {8'h00, b1}};
            end
          end
          OPC_MOV_SADDR_IMM:
          begin
            o.op = OP_MOV_SADDR_IMM;
            base_len = LEN_3;
            o.addr = saddr_map(b1);
            o.imm8 = b2;
          end
          OPC_MOV_SFR_IMM:
          begin
            o.op = OP_MOV_SFR_IMM;
            base_len = LEN_3;
            o.addr = SFR_BASE | {12'h000, b1};
            o.imm8 = b2;
          end
          OPC_MOV_STATE_IMM:
          begin
            o.op = OP_MOV_STATE_IMM;
            base_len = LEN_3;
            base_cyc = CYC_3;
            o.imm8 = b1;
            // Whole program_state_word replaced, flags follow the value
            o.flags = '{FA_RESULT, FA_RESULT, FA_RESULT};
          end
          OPC_MOVW_SADDRP:
          begin
            o.op = OP_MOVW_SADDRP;
            base_len = LEN_4;
            o.word = 1'b1;
            o.addr = word_even(saddr_map(b1));
            o.imm16 = {b3, b2};
          end
          OPC_MOVW_SFRP:
          begin
            o.op = OP_MOVW_SFRP;
            base_len = LEN_4;
            o.word = 1'b1;
            o.addr = word_even(SFR_BASE | {12'h000, b1});
            o.imm16 = {b3, b2};
          end
          OPC_MOVW_AX_ABS:
          begin
            o.op = OP_MOVW_AX_ABS;
            base_len = LEN_3;
            uses_seg = 1'b1;
            o.word = 1'b1;
            o.addr = word_even(ext_addr(pfx, state_ff.extension_segment_reg, {b2, b1}));
            o.dst = PAIR_AX;
          end
          OPC_SWAP_X:
          begin
            o.op = OP_SWAP_X;
            base_len = LEN_1;
            o.dst = REG_X;
            nxt_state.gpr[REG_A] = state_ff.gpr[REG_X];
            nxt_state.gpr[REG_X] = state_ff.gpr[REG_A];
          end
          OPC_SWAP_R:
          begin
            o.op = OP_SWAP_R;
            base_len = LEN_2;
            o.dst = b1[2:0];
            nxt_state.gpr[REG_A] = state_ff.gpr[b1[2:0]];
            nxt_state.gpr[b1[2:0]] = state_ff.gpr[REG_A];
          end
          OPC_UNITY_X, OPC_UNITY_A:
          begin
            o.op = OP_LOAD_UNITY;
            o.dst = {2'b00, b0[0]};
            o.imm8 = UNITY_VALUE;
            nxt_state.gpr[{2'b00, b0[0]}] = UNITY_VALUE;
          end
          OPC_BR_SHORT:
          begin
            o.op = OP_BR_SHORT;
            base_len = LEN_2;
            // Signed 8-bit displacement from the next instruction
            o.addr = dec_req.pc + 20'(LEN_2) + {{12{b1[7]}}, b1};
            o.imm8 = b1;
          end
          OPC_BR_LONG:
          begin
            o.op = OP_BR_LONG;
            base_len = LEN_3;
            o.addr = dec_req.pc + 20'(LEN_3) + {{4{b2[7]}}, b2, b1};
            o.imm16 = {b2, b1};
          end
          OPC_BR_ABS20:
          begin
            o.op = OP_BR_ABS20;
            base_len = LEN_4;
            // Segment nibble, high byte, low byte
            o.addr = '{seg: b3[3:0], hi: b2, lo: b1};
          end
          OPC_VECTOR_CALL:
          begin
            o.op = OP_VECTOR_CALL;
            base_len = LEN_2;
            // Even entries inside the table only
            o.addr = VECTOR_BASE + {14'h0000, b1[4:0], 1'b0};
          end
          OPC_SET_BIT:
          begin
            o.op = OP_SET_BIT;
            base_len = LEN_3;
            o.imm_bit = b1[2:0];
            o.addr = saddr_map(b2);
          end
          default:
          begin
            o.op = OP_ILLEGAL;
          end
        endcase
        o.bytes = base_len + {2'b00, pfx};
        o.cycles = base_cyc + {1'b0, pfx & uses_seg};
        nxt_state.last_pfx = pfx;
      end
    end
    nxt_state.out = o.valid ? o : nxt_state.out;
    nxt_state.out.valid = o.valid;

    // Software writes land last so they win over same-cycle decode effects
    if (reg_bus.wr)
    begin
      if (reg_bus.addr <= OFS_GPR_LAST)
      begin
        nxt_state.gpr[reg_bus.addr[2:0]] = reg_bus.wdata;
      end
      else if (reg_bus.addr == OFS_SEG)
      begin
        nxt_state.extension_segment_reg = reg_bus.wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Outputs
  // Interrupt held off while a prefix waits
  assign irq_take = irq_req & interrupt_accept_bit & ~state_ff.pend;
  assign dec_out = state_ff.out;
  assign reg_rdata = state_ff.rdata;
  assign acc_byte = state_ff.gpr[REG_A];
  assign acc_word = {state_ff.gpr[REG_A], state_ff.gpr[REG_X]};

  // ==========================================================================
  // Checks
  a_seg_extend: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && dec_out.prefixed && (dec_out.op == OP_MOV_ABS_IMM || dec_out.op == OP_MOV_A_HL)
    |-> dec_out.addr.seg == $past(state_ff.extension_segment_reg))
    else $error("prefixed address lost the segment");

  a_prefix_once: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_req.valid && dec_req.code[39:32] != OPC_PREFIX ##1 dec_req.valid && dec_req.code[39:32] != OPC_PREFIX
    |=> !dec_out.prefixed)
    else $error("segment extension reached a second instruction");

  a_irq_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_req.valid && dec_req.code[39:32] == OPC_PREFIX |=> !irq_take && state_ff.pend)
    else $error("interrupt accepted after a prefix");

  a_prefix_seen: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_req.valid && dec_req.code[39:32] == OPC_PREFIX |=> state_ff.pend && !dec_out.valid)
    else $error("prefix byte not recognised");

  a_swap_data: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_req.valid && dec_req.code[39:32] == OPC_SWAP_R && !reg_bus.wr
    |=> acc_byte == $past(state_ff.gpr[dec_req.code[26:24]]))
    else $error("swap used the wrong register");

  a_word_even: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && dec_out.word |-> dec_out.addr.lo[0] == 1'b0)
    else $error("word access at odd address");

  a_saddr_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && dec_out.op == OP_MOV_SADDR_IMM
    |-> dec_out.addr >= 20'hFFE20 && dec_out.addr <= 20'hFFF1F)
    else $error("short-direct address out of range");

  a_sfr_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && dec_out.op == OP_MOV_SFR_IMM |-> dec_out.addr >= 20'hFFF00)
    else $error("special-function address out of range");

  a_vector_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && dec_out.op == OP_VECTOR_CALL
    |-> dec_out.addr >= 20'h00080 && dec_out.addr <= 20'h000BF && !dec_out.addr.lo[0])
    else $error("vector table address out of range");

  a_hld_length: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_ff.pend && dec_req.valid && dec_req.code[39:32] == OPC_MOV_HLD_IMM
    |=> dec_out.bytes == 3'h4 && dec_out.cycles == 2'h2)
    else $error("prefixed indexed store has wrong length");

  a_swap_length: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_out.valid && !dec_out.prefixed && (dec_out.op == OP_SWAP_X || dec_out.op == OP_SWAP_R)
    |-> dec_out.bytes == ((dec_out.op == OP_SWAP_X) ? 3'h1 : 3'h2))
    else $error("swap length wrong");

  a_branch_short: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dec_req.valid && dec_req.code[39:32] == OPC_BR_SHORT
    |=> dec_out.addr == $past(dec_req.pc) + 20'h00002 + {{12{$past(dec_req.code[31])}}, $past(dec_req.code[31:24])})
    else $error("short branch target wrong");

endmodule : operand_decoder

// [verification/prog_fetch_model.sv]
// ============================================================================
// Program memory side: holds one fetch line and presents it to the decoder
module prog_fetch_model
  import decode_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic ld_en, // Load a new fetch line
  input wire logic [39:0] ld_code, // Instruction bytes, first byte on top
  input wire logic fetch, // Present the line for this cycle
  input wire logic [19:0] pc, // Address of the opcode byte
  output decode_pkg::dec_req_t dec_req // Request toward the decoder
);
  timeunit 1ns;
  timeprecision 100ps;
  import decode_pkg::*;

  logic [39:0] line_ff;

  always_ff @(posedge clk_sys)
  begin
    if (ld_en)
    begin
      line_ff <= ld_code;
    end
  end

  // Released bus shows the inverse, so a stale line never decodes by luck
  assign dec_req = '{valid: fetch, pc: pc, code: fetch ? line_ff : ~line_ff};
endmodule : prog_fetch_model

// [verification/cpu_operand_decode_move_group_tb.sv]
module cpu_operand_decode_move_group_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import decode_pkg::*;

  typedef struct packed {
    logic pfx;
    logic [39:0] code;
    op_t op;
    logic [2:0] len;
    logic [1:0] cyc;
    logic [19:0] addr;
    logic word;
    logic ca;
  } row_t;

  logic clk_sys, rst_n, ld_en, fetch, irq_req, interrupt_accept_bit, irq_take;
  logic [39:0] ld_code;
  logic [19:0] pc;
  logic [7:0] acc_byte, reg_rdata, v;
  logic [15:0] acc_word;
  dec_req_t dec_req;
  dec_out_t dec_out;
  reg_req_t reg_bus;
  flag_ctl_t ef;
  row_t rows [0:22];
  int mismatches, compares;

  prog_fetch_model u_prog_fetch_model (.clk_sys(clk_sys), .ld_en(ld_en), .ld_code(ld_code), .fetch(fetch),
    .pc(pc), .dec_req(dec_req));
  operand_decoder u_operand_decoder (.clk_sys(clk_sys), .rst_n(rst_n), .dec_req(dec_req), .irq_req(irq_req),
    .interrupt_accept_bit(interrupt_accept_bit), .irq_take(irq_take), .dec_out(dec_out), .acc_byte(acc_byte),
    .acc_word(acc_word), .reg_bus(reg_bus), .reg_rdata(reg_rdata));

  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic issue(input logic [39:0] code);
    @(posedge clk_sys);
    ld_en <= 1'b1;
    ld_code <= code;
    @(posedge clk_sys);
    ld_en <= 1'b0;
    fetch <= 1'b1;
    @(posedge clk_sys);
    fetch <= 1'b0;
    #1;
  endtask : issue

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_bus.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_bus.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence; HL is FFF0H and the segment is 3 for every row
  initial
  begin
    rows = '{
      '{1'b1, 40'hCF3512AB00, OP_MOV_ABS_IMM, 3'h5, 2'h2, 20'h31235, 1'b0, 1'b1},
      '{1'b0, 40'hCF3512AB00, OP_MOV_ABS_IMM, 3'h4, 2'h1, 20'hF1235, 1'b0, 1'b1},
      '{1'b1, 40'h8B00000000, OP_MOV_A_HL, 3'h2, 2'h2, 20'h3FFF0, 1'b0, 1'b1},
      '{1'b0, 40'h8B00000000, OP_MOV_A_HL, 3'h1, 2'h1, 20'hFFFF0, 1'b0, 1'b1},
      '{1'b1, 40'hCA20770000, OP_MOV_HLD_IMM, 3'h4, 2'h2, 20'h40010, 1'b0, 1'b1},
      '{1'b0, 40'hCA20770000, OP_MOV_HLD_IMM, 3'h3, 2'h1, 20'hF0010, 1'b0, 1'b1},
      '{1'b0, 40'hCD1F550000, OP_MOV_SADDR_IMM, 3'h3, 2'h1, 20'hFFF1F, 1'b0, 1'b1},
      '{1'b0, 40'hCD20550000, OP_MOV_SADDR_IMM, 3'h3, 2'h1, 20'hFFE20, 1'b0, 1'b1},
      '{1'b0, 40'hCCFF550000, OP_MOV_SFR_IMM, 3'h3, 2'h1, 20'hFFFFF, 1'b0, 1'b1},
      '{1'b0, 40'hC921341200, OP_MOVW_SADDRP, 3'h4, 2'h1, 20'hFFE20, 1'b1, 1'b1},
      '{1'b0, 40'hCB03341200, OP_MOVW_SFRP, 3'h4, 2'h1, 20'hFFF02, 1'b1, 1'b1},
      '{1'b0, 40'hAF35120000, OP_MOVW_AX_ABS, 3'h3, 2'h1, 20'hF1234, 1'b1, 1'b1},
      '{1'b0, 40'hEF80000000, OP_BR_SHORT, 3'h2, 2'h1, 20'h00082, 1'b0, 1'b1},
      '{1'b0, 40'hEEFEFF0000, OP_BR_LONG, 3'h3, 2'h1, 20'h00101, 1'b0, 1'b1},
      '{1'b0, 40'hEC34120500, OP_BR_ABS20, 3'h4, 2'h1, 20'h51234, 1'b0, 1'b1},
      '{1'b0, 40'h841F000000, OP_VECTOR_CALL, 3'h2, 2'h1, 20'h000BE, 1'b0, 1'b1},
      '{1'b0, 40'h7105210000, OP_SET_BIT, 3'h3, 2'h1, 20'hFFE21, 1'b0, 1'b1},
      '{1'b0, 40'h0800000000, OP_SWAP_X, 3'h1, 2'h1, 20'h00000, 1'b0, 1'b0},
      '{1'b0, 40'h6103000000, OP_SWAP_R, 3'h2, 2'h1, 20'h00000, 1'b0, 1'b0},
      '{1'b0, 40'hE100000000, OP_LOAD_UNITY, 3'h1, 2'h1, 20'h00000, 1'b0, 1'b0},
      '{1'b0, 40'hE000000000, OP_LOAD_UNITY, 3'h1, 2'h1, 20'h00000, 1'b0, 1'b0},
      '{1'b0, 40'hCE55000000, OP_MOV_STATE_IMM, 3'h3, 2'h3, 20'h00000, 1'b0, 1'b0},
      '{1'b0, 40'hFF00000000, OP_ILLEGAL, 3'h1, 2'h1, 20'h00000, 1'b0, 1'b0}};
    clk_sys = 1'b0;
    rst_n = 1'b0;
    ld_en = 1'b0;
    ld_code = '0;
    fetch = 1'b0;
    pc = 20'h00100;
    irq_req = 1'b0;
    interrupt_accept_bit = 1'b0;
    reg_bus = '0;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("dec_out.valid", 20'h0, dec_out.valid);
    reg_rd(OFS_SEG, v);
    chk("segment", 20'h0, v);
    reg_wr(4'h0, 8'hA5);
    reg_wr(4'h1, 8'h5A);
    reg_wr(4'h6, 8'hF0);
    reg_wr(4'h7, 8'hFF);
    reg_wr(4'h3, 8'h3C);
    reg_wr(OFS_SEG, 8'h03);
    reg_wr(4'hF, 8'h77);
    #1;
    chk("acc_word", 20'h05AA5, acc_word);
    chk("acc_byte", 20'h0005A, acc_byte);
    reg_rd(4'hF, v);
    chk("unmapped read", 20'h0, v);
    reg_rd(4'h6, v);
    chk("register L", 20'h000F0, v);
    // ========================================================================
    // Table of ordinary decodes
    foreach (rows[i])
    begin
      if (rows[i].pfx)
      begin
        issue({OPC_PREFIX, 32'h0});
        chk("prefix gives no output", 20'h0, dec_out.valid);
      end
      issue(rows[i].code);
      ef = (rows[i].op == OP_MOV_STATE_IMM) ? flag_ctl_t'{FA_RESULT, FA_RESULT, FA_RESULT} :
        flag_ctl_t'{FA_KEEP, FA_KEEP, FA_KEEP};
      chk("valid", 20'h1, dec_out.valid);
      chk("op", rows[i].op, dec_out.op);
      chk("bytes", rows[i].len, dec_out.bytes);
      chk("cycles", rows[i].cyc, dec_out.cycles);
      chk("prefixed", rows[i].pfx, dec_out.prefixed);
      chk("word", rows[i].word, dec_out.word);
      chk("flags", ef, dec_out.flags);
      if (rows[i].ca)
        chk("addr", rows[i].addr, dec_out.addr);
      if (rows[i].op == OP_MOVW_SADDRP)
        chk("imm16", 20'h01234, dec_out.imm16);
      if (rows[i].op == OP_SET_BIT)
        chk("imm_bit", 20'h00005, dec_out.imm_bit);
    end
    chk("acc_byte unity", UNITY_VALUE, acc_byte);
    chk("acc_word unity", 20'h00101, acc_word);
    reg_rd(4'h3, v);
    chk("register B swapped", 20'h000A5, v);
    // ========================================================================
    // Prefix, then two back-to-back loads: only the first one is extended
    issue({OPC_PREFIX, 32'h0});
    @(posedge clk_sys);
    ld_en <= 1'b1;
    ld_code <= {OPC_MOV_A_HL, 32'h0};
    @(posedge clk_sys);
    ld_en <= 1'b0;
    fetch <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("first prefixed", 20'h1, dec_out.prefixed);
    chk("first addr", 20'h3FFF0, dec_out.addr);
    @(posedge clk_sys);
    fetch <= 1'b0;
    #1;
    chk("second valid", 20'h1, dec_out.valid);
    chk("second prefixed", 20'h0, dec_out.prefixed);
    chk("second addr", 20'hFFFF0, dec_out.addr);
    // ========================================================================
    // Interrupt held off between prefix and its instruction
    @(posedge clk_sys);
    irq_req <= 1'b1;
    interrupt_accept_bit <= 1'b1;
    #1;
    chk("irq_take open", 20'h1, irq_take);
    issue({OPC_PREFIX, 32'h0});
    chk("irq_take after prefix", 20'h0, irq_take);
    reg_rd(OFS_STAT, v);
    chk("prefix pending", 20'h1, v[STAT_PEND_BIT]);
    chk("irq_take still held", 20'h0, irq_take);
    issue({OPC_MOV_A_HL, 32'h0});
    chk("irq_take after instr", 20'h1, irq_take);
    chk("addr", 20'h3FFF0, dec_out.addr);
    @(posedge clk_sys);
    interrupt_accept_bit <= 1'b0;
    #1;
    chk("irq_take disabled", 20'h0, irq_take);
    // ========================================================================
    // Reset in mid-run drops a pending prefix and clears HL
    issue({OPC_PREFIX, 32'h0});
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    issue({OPC_MOV_A_HL, 32'h0});
    chk("prefixed after reset", 20'h0, dec_out.prefixed);
    chk("addr after reset", 20'hF0000, dec_out.addr);
    wrap_up();
  end
endmodule : cpu_operand_decode_move_group_tb
